// file: design/flash_seq.sv
// Flash erase sequencer as seen inside the flash module, with AXI4-Lite regs.
// Assumes the flash array answers check_addr on check_rdata in the same cycle.
//
// Contract
// RL1: Reprogram mask zero only for 0-data,1-read
// RL2: Additional mask zero only for 0-mask,0-read
// RL3: No extra pulses on finished 128-byte units
// RL4: Set gate, wait, select exactly one block
// RL5: Arm watchdog longer than whole erase pulse
// RL6: Erase setup held before wiping starts
// RL7: Erase lasts exactly while wiping_on set
// RL8: Software keeps each erase pulse short
// RL9: Erase needs no preprogramming to zeros
// RL10: Clear wiping_on, wait, then clear setup
// RL11: Leaving erase mode cancels the watchdog; code keeps it running when a low permit_q forces M_IDLE
// RL12: Verify entry wait, then all-ones dummy write
// RL13: Verify read waits, returns latched 16-bit word
// RL14: All ones continues, otherwise erase again
// RL15: Erase repetitions bounded by loop limit
// RL16: Clear verify, wait, clear gate, wait
// RL17: Next block selected by one bit
// RL18: Write-permit pin low blocks program/erase
// RL19: Additional programming only for loops 1-6
`timescale 1ns/1ps
`default_nettype none
module flash_seq
  import flash_seq_pkg::*;
#(
  parameter int unsigned NBLK   = 8,
  parameter int unsigned ADDR_W = 16
) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write channels
  input  wire logic [7:0]        awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]        araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Pin
  input  wire logic              write_permit_pin,
  // Flash array side
  output logic                   wipe_pulse,
  output logic [NBLK-1:0]        wipe_blocks,
  output logic                   check_mode,
  output logic [ADDR_W-1:0]      check_addr,
  input  wire logic [15:0]       check_rdata
);

  // Elaboration checks
  if (NBLK < 1 || NBLK > 32) $error("NBLK must be 1..32");
  if (ADDR_W < 1 || ADDR_W > 32) $error("ADDR_W must be 1..32");

  // Verify data is seen by assertions one edge after it latches
  localparam int CRW = int'(CHECK_READ_CYC) + 1;

  // ==========================================================================
  // Write-permit pin synchroniser
  logic [2:0] psync_q;
  logic       permit_q;
  logic       permit_d;

  // Level accepted once second and third stages agree
  always_comb begin
    permit_d = (psync_q[1] == psync_q[2]) ? psync_q[2] : permit_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      psync_q  <= 3'h0;
      permit_q <= 1'b0;
    end else begin
      psync_q  <= {psync_q[1:0], write_permit_pin};
      permit_q <= permit_d;
    end
  end

  // ==========================================================================
  // AXI4-Lite slave
  logic              aw_v_q, aw_v_d, w_v_q, w_v_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]        aw_a_q, aw_a_d;
  logic [31:0]       w_dat_q, w_dat_d, rd_q, rd_d;
  logic [3:0]        w_stb_q, w_stb_d;
  logic [1:0]        br_q, br_d, rr_q, rr_d;
  logic              do_wr;
  logic [31:0]       rmux;
  logic              rhit, whit;

  ctrl_t             ctrl_q, ctrl_d;
  logic [NBLK-1:0]   bsel_q, bsel_d;
  logic [31:0]       dog_q, dog_d;
  logic              dog_on_q, dog_on_d;
  logic              err_q, err_d;
  mode_t             mode_q, mode_d;
  logic [15:0]       cnt_q, cnt_d;
  logic [ADDR_W-1:0] vaddr_q, vaddr_d;
  logic [15:0]       vdata_q, vdata_d;
  logic [15:0]       vcnt_q, vcnt_d;
  logic              vready_q, vready_d, vbusy_q, vbusy_d;
  logic              vstart, one_block;
  logic [31:0]       wmerge;

  // Handshake readies, one outstanding write and read
  assign awready = !aw_v_q && !bv_q;
  assign wready  = !w_v_q && !bv_q;
  assign arready = !rv_q;
  assign bvalid  = bv_q;
  assign bresp   = br_q;
  assign rvalid  = rv_q;
  assign rdata   = rd_q;
  assign rresp   = rr_q;
  assign do_wr   = aw_v_q && w_v_q;

  // Read decode of block state
  always_comb begin
    rhit = 1'b1;
    unique case (araddr)
      CTRL_OFS:  rmux = {25'h000_0000, ctrl_q};
      BSEL_OFS:  rmux = 32'(bsel_q);
      WDOG_OFS:  rmux = dog_q;
      STAT_OFS:  rmux = {26'h000_0000, dog_on_q, err_q, vready_q, permit_q, mode_q};
      VADDR_OFS: rmux = 32'(vaddr_q);
      VDATA_OFS: rmux = {16'h0000, vdata_q};
      default: begin
        rmux = WORD_ZERO;
        rhit = 1'b0;
      end
    endcase
  end

  // Bus channel next state; writes land the cycle after both halves are held
  always_comb begin
    aw_v_d  = aw_v_q;
    aw_a_d  = aw_a_q;
    w_v_d   = w_v_q;
    w_dat_d = w_dat_q;
    w_stb_d = w_stb_q;
    bv_d    = bv_q && !bready;
    br_d    = br_q;
    rv_d    = rv_q && !rready;
    rd_d    = rd_q;
    rr_d    = rr_q;
    whit    = (aw_a_q == CTRL_OFS) || (aw_a_q == BSEL_OFS) || (aw_a_q == WDOG_OFS) ||
              (aw_a_q == STAT_OFS) || (aw_a_q == VADDR_OFS) || (aw_a_q == VDATA_OFS);
    if (awvalid && awready) begin
      aw_v_d = 1'b1;
      aw_a_d = awaddr;
    end
    if (wvalid && wready) begin
      w_v_d   = 1'b1;
      w_dat_d = wdata;
      w_stb_d = wstrb;
    end
    if (do_wr) begin
      aw_v_d = 1'b0;
      w_v_d  = 1'b0;
      bv_d   = 1'b1;
      br_d   = whit ? RESP_OKAY : RESP_SLVERR;
    end
    if (arvalid && arready) begin
      rv_d = 1'b1;
      rd_d = rmux;
      rr_d = rhit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_v_q  <= 1'b0;
      aw_a_q  <= 8'h00;
      w_v_q   <= 1'b0;
      w_dat_q <= WORD_ZERO;
      w_stb_q <= 4'h0;
      bv_q    <= 1'b0;
      br_q    <= RESP_OKAY;
      rv_q    <= 1'b0;
      rd_q    <= WORD_ZERO;
      rr_q    <= RESP_OKAY;
    end else begin
      aw_v_q  <= aw_v_d;
      aw_a_q  <= aw_a_d;
      w_v_q   <= w_v_d;
      w_dat_q <= w_dat_d;
      w_stb_q <= w_stb_d;
      bv_q    <= bv_d;
      br_q    <= br_d;
      rv_q    <= rv_d;
      rd_q    <= rd_d;
      rr_q    <= rr_d;
    end
  end

  // ==========================================================================
  // Erase sequencer core
  assign one_block = (bsel_q != '0) && ((bsel_q & (bsel_q - 1'b1)) == '0);
  // RL12 dummy write latches the verify address
  assign vstart    = do_wr && (aw_a_q == VADDR_OFS) && (ctrl_q.wipe_check_bit ||
                     ctrl_q.burn_check_bit);

  // Byte lanes merged into the old value of the addressed register
  always_comb begin
    wmerge = rmux;
    unique case (aw_a_q)
      CTRL_OFS:  wmerge = {25'h000_0000, ctrl_q};
      BSEL_OFS:  wmerge = 32'(bsel_q);
      WDOG_OFS:  wmerge = dog_q;
      VADDR_OFS: wmerge = 32'(vaddr_q);
      default:   wmerge = WORD_ZERO;
    endcase
    for (int i = 0; i < 4; i++) begin
      if (w_stb_q[i]) wmerge[8*i +: 8] = w_dat_q[8*i +: 8];
    end
  end

  // Register writes, erase mode tracking, watchdog and verify timing
  always_comb begin
    ctrl_d   = ctrl_q;
    bsel_d   = bsel_q;
    dog_d    = dog_q;
    dog_on_d = dog_on_q;
    err_d    = err_q;
    mode_d   = mode_q;
    cnt_d    = cnt_q;
    vaddr_d  = vaddr_q;
    vdata_d  = vdata_q;
    vcnt_d   = vcnt_q;
    vready_d = vready_q;
    vbusy_d  = vbusy_q;
    if (do_wr) begin
      unique case (aw_a_q)
        CTRL_OFS: ctrl_d = ctrl_t'(wmerge[6:0]);
        BSEL_OFS: bsel_d = wmerge[NBLK-1:0];
        WDOG_OFS: begin
          dog_d    = wmerge;
          dog_on_d = (wmerge != WORD_ZERO);
        end
        VADDR_OFS: vaddr_d = vstart ? wmerge[ADDR_W-1:0] : vaddr_q;
        default: ;
      endcase
    end
    // Watchdog counts down; overflow aborts erasing until reset
    // A software rewrite of the count wins over the tick
    if (dog_on_q && !(do_wr && (aw_a_q == WDOG_OFS))) begin
      dog_d = dog_q - 32'h0000_0001;
      if (dog_q == 32'h0000_0001) begin
        dog_on_d = 1'b0;
        err_d    = 1'b1;
      end
    end
    // RL6 setup wait counted before erase mode may start
    unique case (mode_q)
      M_IDLE: begin
        cnt_d = 16'h0000;
        if (ctrl_q.flash_write_gate && ctrl_q.erase_setup_bit && one_block && !err_q) begin
          mode_d = M_SETUP;
        end
      end
      M_SETUP: begin
        cnt_d = cnt_q + 16'h0001;
        if (!ctrl_q.erase_setup_bit) begin
          mode_d = M_IDLE;
        end else if (cnt_q >= 16'(WIPE_SETUP_CYC - 1)) begin
          mode_d = M_ARMED;
        end
      end
      M_ARMED: begin
        // RL11 exit from erase mode drops the watchdog
        if (!ctrl_q.erase_setup_bit) begin
          mode_d   = M_IDLE;
          dog_on_d = 1'b0;
          dog_d    = WORD_ZERO;
        // RL9 no preprogram state gates the erase
        end else if (ctrl_q.wiping_on) begin
          mode_d = M_WIPE;
        end
      end
      M_WIPE: begin
        // RL7 erase ends with wiping_on
        if (!ctrl_q.wiping_on) mode_d = M_ARMED;
      end
    endcase
    if (err_d && !err_q) mode_d = M_IDLE;
    // RL13 read data valid only after the wait
    if (vstart) begin
      vbusy_d  = 1'b1;
      vready_d = 1'b0;
      vcnt_d   = 16'h0000;
    end else if (vbusy_q) begin
      vcnt_d = vcnt_q + 16'h0001;
      if (vcnt_q >= 16'(CHECK_READ_CYC - 1)) begin
        vbusy_d  = 1'b0;
        vready_d = 1'b1;
        vdata_d  = check_rdata;
      end
    end
    // RL18 low permit clears controls and protects the array
    if (!permit_q) begin
      ctrl_d = ctrl_t'(CTRL_RST);
      bsel_d = '0;
      mode_d = M_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q   <= ctrl_t'(CTRL_RST);
      bsel_q   <= '0;
      dog_q    <= WORD_ZERO;
      dog_on_q <= 1'b0;
      err_q    <= 1'b0;
      mode_q   <= M_IDLE;
      cnt_q    <= 16'h0000;
      vaddr_q  <= '0;
      vdata_q  <= VDATA_RST;
      vcnt_q   <= 16'h0000;
      vready_q <= 1'b0;
      vbusy_q  <= 1'b0;
    end else begin
      ctrl_q   <= ctrl_d;
      bsel_q   <= bsel_d;
      dog_q    <= dog_d;
      dog_on_q <= dog_on_d;
      err_q    <= err_d;
      mode_q   <= mode_d;
      cnt_q    <= cnt_d;
      vaddr_q  <= vaddr_d;
      vdata_q  <= vdata_d;
      vcnt_q   <= vcnt_d;
      vready_q <= vready_d;
      vbusy_q  <= vbusy_d;
    end
  end

  // Array side outputs, all decoded from flops
  assign wipe_pulse  = (mode_q == M_WIPE);
  assign wipe_blocks = (mode_q == M_WIPE) ? bsel_q : '0;
  assign check_mode  = ctrl_q.wipe_check_bit || ctrl_q.burn_check_bit;
  assign check_addr  = vaddr_q;

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_wipe_after_setup: assert property ($rose(wipe_pulse) |-> ctrl_q.erase_setup_bit &&
    $past(mode_q) == M_ARMED) else $error("erase began without setup wait"); // RL6
  a_wipe_ends_bit: assert property (wipe_pulse && !ctrl_q.wiping_on |=> !wipe_pulse)
    else $error("erase outlived wiping_on"); // RL7
  a_wipe_no_preprog: assert property (mode_q == M_ARMED && ctrl_q.wiping_on &&
    ctrl_q.erase_setup_bit && permit_q && !err_d |=> wipe_pulse)
    else $error("erase refused without reason"); // RL9
  a_dog_cancel: assert property (mode_q == M_ARMED && !ctrl_q.erase_setup_bit |=>
    !dog_on_q && mode_q == M_IDLE) else $error("watchdog kept after erase exit"); // RL11
  a_check_early: assert property (vstart |=> !vready_q [*5])
    else $error("verify data ready too early"); // RL13
  a_check_ready: assert property (vstart |-> ##CRW vready_q && vdata_q == $past(check_rdata))
    else $error("verify data not latched on time"); // RL13
  a_permit_block: assert property (!permit_q |=> !wipe_pulse && ctrl_q == ctrl_t'(CTRL_RST))
    else $error("erase possible without permit"); // RL18

  c_erase_pulse: cover property ($fell(wipe_pulse));
  c_verify_read: cover property (vstart ##CRW vready_q);
  c_dog_abort: cover property ($rose(err_q));

endmodule
`default_nettype wire

// file: design/flash_seq_pkg.sv
// Shared constants and types of the flash erase sequencer.
// Assumes a 10 MHz aclk and an AXI4-Lite register bus of 32-bit words.
package flash_seq_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] BSEL_OFS  = 8'h04;
  localparam logic [7:0] WDOG_OFS  = 8'h08;
  localparam logic [7:0] STAT_OFS  = 8'h0C;
  localparam logic [7:0] VADDR_OFS = 8'h10;
  localparam logic [7:0] VDATA_OFS = 8'h14;

  // ==========================================================================
  // Reset values and answers
  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [31:0] WORD_ZERO  = 32'h0000_0000;
  localparam logic [15:0] VDATA_RST  = 16'hFFFF;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Timing: wait times in microseconds, counts derived at 10 MHz
  localparam int unsigned CLK_HZ         = 10_000_000;
  localparam int unsigned WIPE_SETUP_US  = 100;
  localparam int unsigned CHECK_READ_US  = 2;
  localparam int unsigned WIPE_SETUP_CYC = (WIPE_SETUP_US * CLK_HZ + 999_999) / 1_000_000;
  localparam int unsigned CHECK_READ_CYC = (CHECK_READ_US * CLK_HZ + 999_999) / 1_000_000;

  // ==========================================================================
  // Control word, field order is the bit order from bit 6 down to bit 0
  typedef struct packed {
    logic burn_check_bit;
    logic burn_on;
    logic burn_setup_bit;
    logic wipe_check_bit;
    logic wiping_on;
    logic erase_setup_bit;
    logic flash_write_gate;
  } ctrl_t;

  // Erase sequencing states
  typedef enum logic [1:0] {
    M_IDLE  = 2'b00,
    M_SETUP = 2'b01,
    M_ARMED = 2'b10,
    M_WIPE  = 2'b11
  } mode_t;

endpackage

// file: test/flash_seq_test.sv
// Self-checking bench for the flash erase sequencer, driven over AXI4-Lite.
// Assumes flash_seq_pkg compiled first and the design at its default sizes.
`timescale 1ns/1ps
`default_nettype none
module flash_seq_test
  import flash_seq_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, write_permit_pin;
  logic        wipe_pulse, check_mode;
  logic [7:0]  awaddr, araddr, wipe_blocks;
  logic [31:0] wdata, rdata, rd_q;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs_q;
  logic [15:0] check_addr, check_rdata;
  int          bad_count, checked;

  flash_seq DUT (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .write_permit_pin(write_permit_pin), .wipe_pulse(wipe_pulse), .wipe_blocks(wipe_blocks),
    .check_mode(check_mode), .check_addr(check_addr), .check_rdata(check_rdata));

  // ==========================================================================
  // Clock and helpers
  always #50 aclk = ~aclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("bad_count=%0d checked=%0d", bad_count, checked);
    if (bad_count == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Write with both halves offered together, bready held until the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      n++;
    end while (!(bvalid && bready) && n < 100);
    if (!(bvalid && bready)) bad_count++;
    chk({30'h0000_0000, bresp}, {30'h0000_0000, er});
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      n++;
    end while (!(rvalid && rready) && n < 100);
    if (!(rvalid && rready)) bad_count++;
    rd_q = rdata;
    rs_q = rresp;
  endtask

  // Read, mask and compare; the response must be OKAY
  task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    rd(a);
    chk(rd_q & m, e);
    chk({30'h0000_0000, rs_q}, {30'h0000_0000, RESP_OKAY});
  endtask

  // ==========================================================================
  // Watchdog, well beyond the two setup waits plus traffic
  initial begin
    repeat (8000) @(posedge aclk);
    bad_count++;
    final_report();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    aclk = 1'b0; aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0;
    arvalid = 1'b0; rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0000_0000;
    wstrb = 4'hF; write_permit_pin = 1'b1; check_rdata = 16'hFFFF;
    bad_count = 0; checked = 0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    // Let the permit synchroniser fill
    repeat (8) @(posedge aclk);
    rc(CTRL_OFS, 32'hFFFF_FFFF, {25'h000_0000, CTRL_RST});
    rc(BSEL_OFS, 32'hFFFF_FFFF, WORD_ZERO);
    rc(VDATA_OFS, 32'h0000_FFFF, {16'h0000, VDATA_RST});
    // Unmapped place answers with an error and reads zero
    rd(8'h18);
    chk(rd_q, WORD_ZERO);
    chk({30'h0000_0000, rs_q}, {30'h0000_0000, RESP_SLVERR});
    wr(8'h18, 32'hFFFF_FFFF, RESP_SLVERR);

    // two selected blocks never start setup
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    wr(BSEL_OFS, 32'h0000_0003, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
    repeat (4) @(posedge aclk);
    rc(STAT_OFS, 32'h0000_0003, 32'h0000_0000);

    // early wiping_on waits out the setup time
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    wr(BSEL_OFS, 32'h0000_0004, RESP_OKAY);
    wr(WDOG_OFS, 32'h0000_4000, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0007, RESP_OKAY);
    rc(STAT_OFS, 32'h0000_0037, 32'h0000_0025);
    repeat (WIPE_SETUP_CYC - 30) @(posedge aclk);
    chk({31'h0000_0000, wipe_pulse}, 32'h0000_0000);
    repeat (40) @(posedge aclk);
    // erase lasts while wiping_on, on the chosen block
    chk({31'h0000_0000, wipe_pulse}, 32'h0000_0001);
    chk({24'h00_0000, wipe_blocks}, 32'h0000_0004);
    wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
    // State leaves erase one edge after the write lands
    @(posedge aclk);
    chk({31'h0000_0000, wipe_pulse}, 32'h0000_0000);
    chk({24'h00_0000, wipe_blocks}, 32'h0000_0000);
    rc(STAT_OFS, 32'h0000_0037, 32'h0000_0026);
    // leaving erase mode drops the watchdog
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    rc(STAT_OFS, 32'h0000_0037, 32'h0000_0004);

    // verify mode with dummy writes and delayed reads
    wr(CTRL_OFS, 32'h0000_0009, RESP_OKAY);
    chk({31'h0000_0000, check_mode}, 32'h0000_0001);
    for (int i = 0; i < 2; i++) begin
      check_rdata <= (i == 0) ? 16'hFFFF : 16'h12F4;
      wr(VADDR_OFS, 32'h0000_0040 + 32'(i * 2), RESP_OKAY);
      chk({16'h0000, check_addr}, 32'h0000_0040 + 32'(i * 2));
      rc(STAT_OFS, 32'h0000_0008, 32'h0000_0000);
      repeat (CHECK_READ_CYC) @(posedge aclk);
      rc(STAT_OFS, 32'h0000_0008, 32'h0000_0008);
      rc(VDATA_OFS, 32'h0000_FFFF, (i == 0) ? 32'h0000_FFFF : 32'h0000_12F4);
    end
    // masks from the last verify word, data all zero
    chk({16'h0000, ~rd_q[15:0]}, 32'h0000_ED0B);
    chk({16'h0000, 16'hED0B | rd_q[15:0]}, 32'h0000_FFFF);
    // burn pulses never raised, check path only
    wr(CTRL_OFS, 32'h0000_0041, RESP_OKAY);
    chk({31'h0000_0000, check_mode}, 32'h0000_0001);
    wr(VADDR_OFS, 32'h0000_0080, RESP_OKAY);
    chk({16'h0000, check_addr}, 32'h0000_0080);
    // verify bit cleared before the gate
    wr(CTRL_OFS, 32'h0000_0001, RESP_OKAY);
    chk({31'h0000_0000, check_mode}, 32'h0000_0000);
    // address latches only in check mode
    wr(VADDR_OFS, 32'h0000_0020, RESP_OKAY);
    chk({16'h0000, check_addr}, 32'h0000_0080);

    // permit pin low aborts an erase and clears control
    wr(BSEL_OFS, 32'h0000_0010, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0007, RESP_OKAY);
    repeat (WIPE_SETUP_CYC + 10) @(posedge aclk);
    chk({24'h00_0000, wipe_blocks}, 32'h0000_0010);
    write_permit_pin <= 1'b0;
    repeat (6) @(posedge aclk);
    chk({31'h0000_0000, wipe_pulse}, 32'h0000_0000);
    rc(CTRL_OFS, 32'h0000_007F, 32'h0000_0000);
    rc(BSEL_OFS, 32'h0000_00FF, 32'h0000_0000);
    rc(STAT_OFS, 32'h0000_0007, 32'h0000_0000);
    // short watchdog overflow latches the error
    write_permit_pin <= 1'b1;
    repeat (6) @(posedge aclk);
    wr(WDOG_OFS, 32'h0000_0010, RESP_OKAY);
    repeat (30) @(posedge aclk);
    rc(STAT_OFS, 32'h0000_0037, 32'h0000_0014);
    wr(BSEL_OFS, 32'h0000_0001, RESP_OKAY);
    wr(CTRL_OFS, 32'h0000_0003, RESP_OKAY);
    repeat (4) @(posedge aclk);
    rc(STAT_OFS, 32'h0000_0003, 32'h0000_0000);
    // Mid-run reset clears the latched error
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (8) @(posedge aclk);
    rc(STAT_OFS, 32'h0000_0037, 32'h0000_0004);
    rc(CTRL_OFS, 32'h0000_007F, 32'h0000_0000);
    final_report();
  end
endmodule
`default_nettype wire
